// *** common/sdo_defines.vh ***
// Constants for the expedited SDO server: frame ids, codes, abort values, timing.
// Assumes a 10 MHz clock; included by bare name with an include path to common/.
`ifndef SDO_DEFINES_VH
`define SDO_DEFINES_VH

// ----------------------------------------------------------------------------
// Identifiers
// ----------------------------------------------------------------------------
`define SDO_ID_REQ_BASE 11'h600
`define SDO_ID_RSP_BASE 11'h580

// ----------------------------------------------------------------------------
// Request and response codes
// ----------------------------------------------------------------------------
`define SDO_CMD_WR4 8'h23
`define SDO_CMD_WR2 8'h2b
`define SDO_CMD_WR1 8'h2f
`define SDO_CMD_RD 8'h40
`define SDO_CMD_CANCEL 8'h80
`define SDO_RSP_RD4 8'h43
`define SDO_RSP_RD2 8'h4b
`define SDO_RSP_RD1 8'h4f
`define SDO_RSP_WR 8'h60
`define SDO_RSP_ABORT 8'h80

// ----------------------------------------------------------------------------
// Abort codes
// ----------------------------------------------------------------------------
`define SDO_AB_TOGGLE 32'h05030000
`define SDO_AB_CMD 32'h05040001
`define SDO_AB_ACCESS 32'h06010000
`define SDO_AB_READONLY 32'h06010002
`define SDO_AB_NO_INDEX 32'h06020000
`define SDO_AB_NO_MAP 32'h06040041
`define SDO_AB_MAP_LEN 32'h06040042
`define SDO_AB_NO_SUB 32'h06090011
`define SDO_AB_RANGE 32'h06090030
`define SDO_AB_HIGH 32'h06090031

// ----------------------------------------------------------------------------
// Dictionary answer status (from the dictionary port)
// ----------------------------------------------------------------------------
`define OD_ST_OK 4'h0
`define OD_ST_NO_INDEX 4'h1
`define OD_ST_NO_SUB 4'h2
`define OD_ST_READONLY 4'h3
`define OD_ST_ACCESS 4'h4
`define OD_ST_RANGE 4'h5
`define OD_ST_HIGH 4'h6
`define OD_ST_NO_MAP 4'h7
`define OD_ST_MAP_LEN 4'h8
`define OD_ST_TOGGLE 4'h9

// ----------------------------------------------------------------------------
// Network management states
// ----------------------------------------------------------------------------
`define NMT_INIT 2'h0
`define NMT_PREOP 2'h1
`define NMT_OPER 2'h2
`define NMT_STOP 2'h3

// ----------------------------------------------------------------------------
// Timing: longest wait for the dictionary, in ns, and its cycle count
// ----------------------------------------------------------------------------
`define OD_TIMEOUT_NS 100000
`define CLK_PERIOD_NS 100
`define OD_TIMEOUT_CYC (`OD_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// *** design/sdo_frame_decoder.v ***
// Splits an 8-byte request frame into code, index, subindex and value fields.
// Assumes the frame is held steady by the caller while it is read.
`include "sdo_defines.vh"

module sdo_frame_decoder (
  input wire [63:0] i_frame,
  output wire [7:0] o_code,
  output wire [15:0] o_index,
  output wire [7:0] o_subindex,
  output wire [31:0] o_value,
  output wire o_code_known,
  output wire o_tail_zero
);

  // ----------------------------------------------------------------------------
  // Field extraction, byte n at bits 8n+7..8n
  // ----------------------------------------------------------------------------
  // RULE2 byte 0 code
  assign o_code = i_frame[7:0];
  // RULE3 little-endian index
  assign o_index = {i_frame[23:16], i_frame[15:8]};
  assign o_subindex = i_frame[31:24];
  // RULE5 value from byte 4
  assign o_value = i_frame[63:32];

  // Known request codes
  assign o_code_known = (o_code == `SDO_CMD_WR4) || (o_code == `SDO_CMD_WR2) ||
                        (o_code == `SDO_CMD_WR1) || (o_code == `SDO_CMD_RD) ||
                        (o_code == `SDO_CMD_CANCEL);

  // ----------------------------------------------------------------------------
  // Padding check: unused value bytes must be zero
  // ----------------------------------------------------------------------------
  // RULE6 RULE7 RULE8 zero padding
  assign o_tail_zero = (o_code == `SDO_CMD_WR2) ? (o_value[31:16] == 16'h0000) :
                       (o_code == `SDO_CMD_WR1) ? (o_value[31:8] == 24'h000000) :
                       (o_code == `SDO_CMD_WR4) ? 1'b1 :
                       (o_value == 32'h00000000);

endmodule

// *** design/sdo_frame_encoder.v ***
// Builds an 8-byte response frame from code, index, subindex and payload.
// Assumes the payload has already been trimmed to the answer length.
`include "sdo_defines.vh"

module sdo_frame_encoder (
  input wire [7:0] i_code,
  input wire [15:0] i_index,
  input wire [7:0] i_subindex,
  input wire [31:0] i_payload,
  output wire [63:0] o_frame
);

  // ----------------------------------------------------------------------------
  // Byte packing, lowest byte first
  // ----------------------------------------------------------------------------
  // RULE13 lowest byte first
  // RULE25 echo index fields
  assign o_frame = {i_payload, i_subindex, i_index[15:8], i_index[7:0], i_code};

endmodule

// *** design/sdo_expedited_server.v ***
// Expedited SDO server: takes request frames, asks the object dictionary, answers.
// Assumes a CAN controller delivers received frames with id and 8 data bytes,
// and a dictionary answers each access with a status and read data.
//
// Functional notes
// RULE1 - Server answers read and write requests
// RULE2 - Frames are eight bytes, code byte 0
// RULE3 - Index bytes 1-2 LSB first, subindex 3
// RULE4 - Requests 600h+node, responses 580h+node
// RULE5 - Code 23h writes four bytes
// RULE6 - Code 2Bh writes two bytes
// RULE7 - Code 2Fh writes one byte
// RULE8 - Code 40h reads an entry
// RULE9 - Code 80h cancels the current command
// RULE10 - Read answers 43h, 4Bh or 4Fh
// RULE11 - Write acknowledged with 60h, zero data
// RULE12 - Failure answers 80h with abort code
// RULE13 - Abort code sent lowest byte first
// RULE14 - Unknown code aborts 05040001h
// RULE15 - Missing index aborts 06020000h
// RULE16 - Missing subindex aborts 06090011h
// RULE17 - Read-only 06010002h, other 06010000h
// RULE18 - Write out of limits 06090030h
// RULE19 - Write too high 06090031h
// RULE20 - Unmappable object aborts 06040041h
// RULE21 - Mapping too long aborts 06040042h
// RULE22 - Toggle fault aborts 05030000h
// RULE23 - Node id 1..127, zero never served
// RULE24 - Ignore requests while stopped
// RULE25 - One response echoing index, subindex
`include "sdo_defines.vh"

module sdo_expedited_server (
  input wire i_clk,
  input wire i_rst,
  input wire [6:0] i_node_id,
  input wire [1:0] i_nmt_state,
  input wire i_rx_valid,
  input wire [10:0] i_rx_id,
  input wire [63:0] i_rx_data,
  output wire o_rx_ready,
  output reg o_tx_valid,
  output reg [10:0] o_tx_id,
  output reg [63:0] o_tx_data,
  input wire i_tx_ready,
  output reg o_od_req,
  output reg o_od_write,
  output reg [15:0] o_od_index,
  output reg [7:0] o_od_subindex,
  output reg [31:0] o_od_wdata,
  output reg [2:0] o_od_wsize,
  output reg o_od_cancel,
  input wire i_od_done,
  input wire [3:0] i_od_status,
  input wire [31:0] i_od_rdata,
  input wire [2:0] i_od_rsize,
  output wire o_busy
);

  // ----------------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;
  localparam [31:0] TIMEOUT_FULL = `OD_TIMEOUT_CYC;
  // Count fits in 16 bits; the upper bits are zero
  localparam [15:0] TIMEOUT_CYC = TIMEOUT_FULL[15:0];

  reg [1:0] state;
  reg [1:0] next_state;
  reg [63:0] req_frame;
  reg [15:0] wait_cnt;
  reg [7:0] rsp_code;
  reg [31:0] rsp_payload;

  wire [7:0] dec_code;
  wire [15:0] dec_index;
  wire [7:0] dec_subindex;
  wire [31:0] dec_value;
  wire dec_known;
  wire dec_tail_zero;
  wire [63:0] enc_frame;
  wire [63:0] dec_frame;
  wire [7:0] rx_code;
  wire addressed;
  wire serving;
  wire take;

  // Map a dictionary status to its abort code
  function [31:0] abort_of;
    input [3:0] st;
    begin
      case (st)
        // RULE15 missing index
        `OD_ST_NO_INDEX: abort_of = `SDO_AB_NO_INDEX;
        // RULE16 missing subindex
        `OD_ST_NO_SUB: abort_of = `SDO_AB_NO_SUB;
        // RULE17 read-only entry
        `OD_ST_READONLY: abort_of = `SDO_AB_READONLY;
        // RULE18 outside limits
        `OD_ST_RANGE: abort_of = `SDO_AB_RANGE;
        // RULE19 value too high
        `OD_ST_HIGH: abort_of = `SDO_AB_HIGH;
        // RULE20 cannot be mapped
        `OD_ST_NO_MAP: abort_of = `SDO_AB_NO_MAP;
        // RULE21 mapping too long
        `OD_ST_MAP_LEN: abort_of = `SDO_AB_MAP_LEN;
        // RULE22 toggle not alternated
        `OD_ST_TOGGLE: abort_of = `SDO_AB_TOGGLE;
        default: abort_of = `SDO_AB_ACCESS;
      endcase
    end
  endfunction

  // Byte count of a write code
  function [2:0] size_of;
    input [7:0] code;
    begin
      if (code == `SDO_CMD_WR4) begin
        size_of = 3'd4;
      end else if (code == `SDO_CMD_WR2) begin
        size_of = 3'd2;
      end else begin
        size_of = 3'd1;
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Frame decode and encode
  // ----------------------------------------------------------------------------
  sdo_frame_decoder u_dec (
    .i_frame(dec_frame),
    .o_code(dec_code),
    .o_index(dec_index),
    .o_subindex(dec_subindex),
    .o_value(dec_value),
    .o_code_known(dec_known),
    .o_tail_zero(dec_tail_zero)
  );

  sdo_frame_encoder u_enc (
    .i_code(rsp_code),
    .i_index(dec_index),
    .i_subindex(dec_subindex),
    .i_payload(rsp_payload),
    .o_frame(enc_frame)
  );

  // ----------------------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------------------
  // RULE4 RULE23 own request id
  assign addressed = (i_node_id != 7'h00) &&
                     (i_rx_id == (`SDO_ID_REQ_BASE + {4'h0, i_node_id}));
  // RULE24 serve preop and operational
  assign serving = (i_nmt_state == `NMT_PREOP) || (i_nmt_state == `NMT_OPER);
  assign rx_code = i_rx_data[7:0];
  // Decode the incoming frame while idle, the held request afterwards
  assign dec_frame = (state == ST_IDLE) ? i_rx_data : req_frame;
  // Frames for others or while stopped are consumed silently
  assign o_rx_ready = (state == ST_IDLE) || (state == ST_WAIT);
  assign take = i_rx_valid && o_rx_ready && addressed && serving;
  assign o_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // RULE1 serve read and write
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (take && (rx_code == `SDO_CMD_CANCEL)) begin
          next_state = ST_IDLE;
        end else if (o_od_req == 1'b0) begin
          // A lone cancel with nothing running has no answer
          if (dec_code == `SDO_CMD_CANCEL) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_SEND;
          end
        end else if (i_od_done || (wait_cnt == TIMEOUT_CYC - 16'd1)) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        // Leave only once the frame enters the response register
        if (!o_tx_valid) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Request capture, dictionary access and response build
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      req_frame <= 64'h0;
      wait_cnt <= 16'h0;
      rsp_code <= 8'h00;
      rsp_payload <= 32'h0;
      o_od_req <= 1'b0;
      o_od_write <= 1'b0;
      o_od_index <= 16'h0;
      o_od_subindex <= 8'h00;
      o_od_wdata <= 32'h0;
      o_od_wsize <= 3'd0;
      o_od_cancel <= 1'b0;
    end else begin
      state <= next_state;
      o_od_cancel <= 1'b0;
      case (state)
        ST_IDLE: begin
          wait_cnt <= 16'h0;
          if (take) begin
            req_frame <= i_rx_data;
            o_od_index <= {i_rx_data[23:16], i_rx_data[15:8]};
            o_od_subindex <= i_rx_data[31:24];
            o_od_wdata <= i_rx_data[63:32];
            // RULE5 RULE6 RULE7 write sizes
            o_od_write <= (rx_code == `SDO_CMD_WR4) || (rx_code == `SDO_CMD_WR2) ||
                          (rx_code == `SDO_CMD_WR1);
            o_od_wsize <= size_of(rx_code);
            // RULE8 well-formed accesses only
            o_od_req <= dec_known && (dec_code != `SDO_CMD_CANCEL) && dec_tail_zero;
          end
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 16'd1;
          if (take && (rx_code == `SDO_CMD_CANCEL)) begin
            // RULE9 cancel drops command
            o_od_cancel <= o_od_req;
            o_od_req <= 1'b0;
          end else if (o_od_req == 1'b0) begin
            // RULE14 unknown or malformed code
            rsp_code <= `SDO_RSP_ABORT;
            rsp_payload <= `SDO_AB_CMD;
          end else if (i_od_done) begin
            o_od_req <= 1'b0;
            if (i_od_status != `OD_ST_OK) begin
              // RULE12 abort response
              rsp_code <= `SDO_RSP_ABORT;
              rsp_payload <= abort_of(i_od_status);
            end else if (o_od_write) begin
              // RULE11 write acknowledge
              rsp_code <= `SDO_RSP_WR;
              rsp_payload <= 32'h0;
            end else if (i_od_rsize == 3'd4) begin
              // RULE10 read answer length
              rsp_code <= `SDO_RSP_RD4;
              rsp_payload <= i_od_rdata;
            end else if (i_od_rsize == 3'd2) begin
              rsp_code <= `SDO_RSP_RD2;
              rsp_payload <= {16'h0000, i_od_rdata[15:0]};
            end else if (i_od_rsize == 3'd1) begin
              rsp_code <= `SDO_RSP_RD1;
              rsp_payload <= {24'h000000, i_od_rdata[7:0]};
            end else begin
              // RULE17 access not possible
              rsp_code <= `SDO_RSP_ABORT;
              rsp_payload <= `SDO_AB_ACCESS;
            end
          end else if (wait_cnt == TIMEOUT_CYC - 16'd1) begin
            // Dictionary never answered
            o_od_req <= 1'b0;
            o_od_cancel <= 1'b1;
            rsp_code <= `SDO_RSP_ABORT;
            rsp_payload <= `SDO_AB_ACCESS;
          end
        end
        default: begin
          wait_cnt <= 16'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Response frame register
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_id <= 11'h000;
      o_tx_data <= 64'h0;
    end else if (o_tx_valid) begin
      if (i_tx_ready) begin
        o_tx_valid <= 1'b0;
      end
    end else if (state == ST_SEND) begin
      // RULE25 exactly one response
      // RULE4 response identifier
      o_tx_valid <= 1'b1;
      o_tx_id <= `SDO_ID_RSP_BASE + {4'h0, i_node_id};
      o_tx_data <= enc_frame;
    end
  end

endmodule

// *** dv/sdo_expedited_server_monitor.sv ***
// Checker for the SDO server ports: frame content and timing.
// Assumes a bind onto the server; sees its ports only.
module sdo_expedited_server_monitor (
  input wire i_clk,
  input wire i_rst,
  input wire [6:0] i_node_id,
  input wire [1:0] i_nmt_state,
  input wire i_rx_valid,
  input wire [10:0] i_rx_id,
  input wire [63:0] i_rx_data,
  input wire o_rx_ready,
  input wire o_tx_valid,
  input wire [10:0] o_tx_id,
  input wire [63:0] o_tx_data,
  input wire i_tx_ready,
  input wire o_od_req,
  input wire o_od_write,
  input wire [15:0] o_od_index,
  input wire [7:0] o_od_subindex,
  input wire [31:0] o_od_wdata,
  input wire [2:0] o_od_wsize,
  input wire i_od_done,
  input wire [3:0] i_od_status,
  input wire o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Frame taken while idle, and whether it is ours
  // ----
  wire take = i_rx_valid && o_rx_ready && !o_busy;
  wire [7:0] rc = i_rx_data[7:0];
  wire ours = take && i_rx_id == 11'h600 + {4'h0, i_node_id} && i_node_id != 7'h0 &&
    (i_nmt_state == 2'h1 || i_nmt_state == 2'h2);
  wire known = rc == 8'h23 || rc == 8'h2b || rc == 8'h2f || rc == 8'h40 || rc == 8'h80;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_rsp_id_node: assert property (o_tx_valid |-> o_tx_id == 11'h580 + {4'h0, i_node_id})
    else $error("response id wrong");
  a_rsp_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("response dropped or changed");
  a_wr_ack_zero: assert property (o_tx_valid && o_tx_data[7:0] == 8'h60 |-> o_tx_data[63:32] == 0)
    else $error("write ack data not zero");
  a_rd_one_pad: assert property (o_tx_valid && o_tx_data[7:0] == 8'h4f |-> o_tx_data[63:40] == 0)
    else $error("one byte read padding");
  a_rd_two_pad: assert property (o_tx_valid && o_tx_data[7:0] == 8'h4b |-> o_tx_data[63:48] == 0)
    else $error("two byte read padding");
  a_read_issue: assert property (ours && rc == 8'h40 && i_rx_data[63:32] == 0 |=> o_od_req &&
    !o_od_write && o_od_index == $past(i_rx_data[23:8]) && o_od_subindex == $past(i_rx_data[31:24]))
    else $error("read access not issued");
  a_write_two: assert property (ours && rc == 8'h2b && i_rx_data[63:48] == 0 |=> o_od_write &&
    o_od_wsize == 3'h2 && o_od_wdata == {16'h0, $past(i_rx_data[47:32])})
    else $error("two byte write wrong");
  a_bad_code: assert property (ours && !known |-> ##3 o_tx_valid &&
    o_tx_data == {32'h05040001, $past(i_rx_data[31:8], 3), 8'h80})
    else $error("unknown code abort wrong");
  a_stop_ignore: assert property (take && i_nmt_state == 2'h3 |=> !o_busy && !o_od_req)
    else $error("frame served while stopped");
  a_done_answer: assert property (o_od_req && i_od_done |-> ##2 o_tx_valid)
    else $error("no response after dictionary");
  a_no_index: assert property (o_od_req && i_od_done && i_od_status == 4'h1 |-> ##2
    o_tx_data[63:32] == 32'h06020000 && o_tx_data[7:0] == 8'h80)
    else $error("missing index abort wrong");

  c_read: cover property (ours && rc == 8'h40);
  c_stall: cover property (o_tx_valid && !i_tx_ready ##1 o_tx_valid);
  c_abort: cover property (o_tx_valid && o_tx_data[7:0] == 8'h80);
endmodule

bind sdo_expedited_server sdo_expedited_server_monitor mon (.*);

// *** dv/sdo_client_model.sv ***
// Model of the network controller acting as SDO client.
// Assumes ready and valid are sampled on the rising clock edge.
module sdo_client_model (
  input wire i_clk,
  input wire i_rx_ready,
  input wire i_tx_valid,
  input wire [10:0] i_tx_id,
  input wire [63:0] i_tx_data,
  output logic o_rx_valid = 1'b0,
  output logic [10:0] o_rx_id = 11'h0,
  output logic [63:0] o_rx_data = 64'h0,
  output logic o_tx_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] rsp_data = 64'h0;
  logic [10:0] rsp_id = 11'h0;
  int rsp_cnt = 0;

  task automatic send(input logic [10:0] id, input logic [63:0] data, output bit ok);
    int n;
    ok = 0;
    o_rx_valid <= 1'b1;
    o_rx_id <= id;
    o_rx_data <= data;
    for (n = 0; n < 2000 && !ok; n++) begin
      @(posedge i_clk);
      ok = i_rx_ready;
    end
    o_rx_valid <= 1'b0;
    o_rx_data <= ~data; // Released lines lose the old value
  endtask

  // Takes responses, stalling at random
  always @(posedge i_clk) begin
    o_tx_ready <= 1'($urandom_range(0, 1));
    if (i_tx_valid && o_tx_ready) begin
      rsp_id <= i_tx_id;
      rsp_data <= i_tx_data;
      rsp_cnt <= rsp_cnt + 1;
    end
  end
endmodule

// *** dv/test_sdo_expedited_server.sv ***
// Self-checking bench for the SDO server with a dictionary model.
// Assumes the client model drives the receive side and takes responses.
module test_sdo_expedited_server;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst = 1, i_rx_valid, i_tx_ready, i_od_done = 0;
  logic [6:0] i_node_id = 7'h04, nd = 7'h04;
  logic [1:0] i_nmt_state = 2'h1;
  logic [10:0] i_rx_id;
  logic [63:0] i_rx_data, q;
  logic [3:0] i_od_status = 0, st = 0;
  logic [31:0] i_od_rdata = 0, rd = 0;
  logic [2:0] i_od_rsize = 0, rs = 0;
  logic [7:0] c;
  wire o_rx_ready, o_tx_valid, o_od_req, o_od_write, o_od_cancel, o_busy;
  wire [10:0] o_tx_id;
  wire [63:0] o_tx_data;
  wire [15:0] o_od_index;
  wire [7:0] o_od_subindex;
  wire [31:0] o_od_wdata;
  wire [2:0] o_od_wsize;
  int n_errors = 0, compares = 0, dly = 0, cnt = 0, n_cancel = 0, i;
  logic [59:0] od_seen = 0;
  bit ok;
  logic [7:0] codes [5] = '{8'h23, 8'h2b, 8'h2f, 8'h40, 8'h55};
  logic [2:0] sizes [4] = '{3'h1, 3'h2, 3'h4, 3'h3};

  always #50 i_clk = ~i_clk;
  sdo_expedited_server dut (.*);
  sdo_client_model client (.i_clk(i_clk), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
    .i_tx_id(o_tx_id), .i_tx_data(o_tx_data), .o_rx_valid(i_rx_valid), .o_rx_id(i_rx_id),
    .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready));

  // ----
  // Dictionary answers after dly cycles
  // ----
  always @(posedge i_clk) begin
    i_od_done <= 1'b0;
    if (!o_od_req) cnt <= 0;
    else if (cnt >= 0) cnt <= (cnt == dly) ? -1 : cnt + 1;
    if (o_od_req && cnt == 0)
      od_seen <= {o_od_write, o_od_wsize, o_od_wdata, o_od_subindex, o_od_index};
    if (o_od_cancel) n_cancel <= n_cancel + 1;
    if (o_od_req && cnt == dly) begin
      i_od_done <= 1'b1;
      i_od_status <= st;
      i_od_rdata <= rd;
      i_od_rsize <= rs;
    end
  end

  task automatic final_report;
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] abort_of(input logic [3:0] s);
    case (s)
      4'h1: return 32'h06020000;
      4'h2: return 32'h06090011;
      4'h3: return 32'h06010002;
      4'h5: return 32'h06090030;
      4'h6: return 32'h06090031;
      4'h7: return 32'h06040041;
      4'h8: return 32'h06040042;
      4'h9: return 32'h05030000;
      default: return 32'h06010000;
    endcase
  endfunction

  function automatic bit well_formed(input logic [63:0] f);
    return f[7:0] == 8'h23 || (f[7:0] == 8'h2b && f[63:48] == 0) ||
      (f[7:0] == 8'h2f && f[63:40] == 0) || (f[7:0] == 8'h40 && f[63:32] == 0);
  endfunction

  function automatic logic [63:0] expect_rsp(input logic [63:0] f, input logic [3:0] s,
      input logic [31:0] r, input logic [2:0] z);
    logic [7:0] k;
    logic [31:0] v;
    k = f[7:0];
    v = 32'h0;
    if (!well_formed(f)) {k, v} = {8'h80, 32'h05040001};
    else if (s != 4'h0) {k, v} = {8'h80, abort_of(s)};
    else if (k != 8'h40) k = 8'h60;
    else if (z == 3'h1) {k, v} = {8'h4f, 24'h0, r[7:0]};
    else if (z == 3'h2) {k, v} = {8'h4b, 16'h0, r[15:0]};
    else if (z == 3'h4) {k, v} = {8'h43, r};
    else {k, v} = {8'h80, 32'h06010000};
    return {v, f[31:8], k};
  endfunction

  task automatic run(input logic [10:0] id, input logic [63:0] f, input logic [3:0] s,
      input logic [31:0] r, input logic [2:0] z, input int d, input bit ans);
    int n0, k;
    n0 = client.rsp_cnt;
    st = s;
    rd = r;
    rs = z;
    dly = d;
    client.send(id, f, ok);
    for (k = 0; k < 1500 && client.rsp_cnt == n0; k++) @(posedge i_clk);
    if (!ok || (ans && k == 1500)) begin
      n_errors++;
      final_report;
    end else begin
      chk(64'(client.rsp_cnt - n0), {63'h0, ans});
      if (ans) chk(client.rsp_data, expect_rsp(f, s, r, z));
      if (ans) chk(64'(client.rsp_id), 64'(11'h580 + i_node_id));
      if (ans && well_formed(f)) begin
        chk(64'(od_seen[23:0]), 64'(f[31:8]));
        chk(64'(od_seen[59]), 64'(f[7:0] != 8'h40));
        if (f[7:0] != 8'h40) chk(64'(od_seen[58:24]),
          {29'h0, 3'(f[7:0] == 8'h23 ? 4 : f[7:0] == 8'h2b ? 2 : 1), f[63:32]});
      end
    end
  endtask

  initial begin
    void'($urandom(39));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    // Read and write of a two-byte entry
    run(11'h604, 64'h00000000_02203c40, 0, 32'h03e8, 3'h2, 2, 1);
    run(11'h604, 64'h000003e8_02203c2b, 0, 0, 0, 0, 1);
    // Every dictionary fault and its abort code
    for (i = 1; i < 10; i++) run(11'h604, {$urandom, 32'h01100023}, 4'(i), 0, 0, 3, 1);
    // Random requests, nodes and answers
    for (i = 0; i < 40; i++) begin
      c = codes[$urandom_range(0, 4)];
      nd = 7'($urandom_range(1, 127));
      i_node_id <= nd;
      i_nmt_state <= 2'($urandom_range(1, 2));
      q = {32'($urandom) & (c == 8'h2f ? 32'hff : c == 8'h2b ? 32'hffff : c == 8'h40 ? 0 : '1),
        8'($urandom), 16'($urandom), c};
      run(11'h600 + nd, q, $urandom_range(0, 2) == 0 ? 4'($urandom_range(1, 9)) : 4'h0,
        $urandom, sizes[$urandom_range(0, 3)], $urandom_range(0, 20), 1);
    end
    // Padding not zero, then no dictionary answer
    run(11'h600 + nd, 64'h00ff0001_00200c2b, 0, 0, 0, 0, 1);
    run(11'h600 + nd, 64'h00000000_00200c40, 4'h4, 0, 0, 5000, 1);
    chk(64'(n_cancel), 64'h1);
    // Frames for another node, while stopped, and to node zero
    run(11'h601 + nd, 64'h00000000_00200c40, 0, 0, 0, 0, 0);
    i_nmt_state <= 2'h3;
    run(11'h600 + nd, 64'h00000000_00200c40, 0, 0, 0, 0, 0);
    i_nmt_state <= 2'h2;
    i_node_id <= 7'h0;
    run(11'h600, 64'h00000000_00200c40, 0, 0, 0, 0, 0);
    i_node_id <= nd;
    // Cancel alone, then cancel of a pending read
    run(11'h600 + nd, 64'h80, 0, 0, 0, 0, 0);
    dly = 5000;
    client.send(11'h600 + nd, 64'h00000000_00200c40, ok);
    repeat (4) @(posedge i_clk);
    run(11'h600 + nd, 64'h80, 0, 0, 0, 5000, 0);
    chk({63'h0, o_od_req}, 64'h0);
    chk(64'(n_cancel), 64'h2);
    run(11'h600 + nd, 64'h00000000_00200c40, 0, 32'h12345678, 3'h4, 0, 1);
    final_report;
  end
endmodule
